/* adsl_map.vh */
/*
 * constants for the attenuator converter serial loader: frame length,
 * control source codes, step size and reset values.
 * assumes inclusion by bare name from the loader files; definitions only.
 */
// Notes on behaviour
// - A transfer carries exactly eight data bits, most significant first, all while select is low; here other lengths still load and set frame_error.
// - While select is low the data input is shifted in on every rising serial clock edge.
// - When select rises the shifted code moves into the converter holding register at once; here the load is seen three clock edges after select is seen high.
// - Converter enable low disables the converter and the external voltage sets attenuation.
// - Enable high with reference select high drives attenuation from the converter on its own reference.
// - Enable high with reference select low drives attenuation from the converter on the external reference.
// - The first bit received becomes code bit 7 and the last becomes bit 0, one unsigned code.
// - Each code step changes attenuation by about 0.12 dB.
`ifndef ADSL_MAP_VH
`define ADSL_MAP_VH

`define ADSL_CODE_WIDTH      8
`define ADSL_CODE_RESET      8'h00
`define ADSL_COUNT_WIDTH     4
`define ADSL_FRAME_BITS      4'h8
`define ADSL_COUNT_MAX       4'hF
// idle levels of the synced pins, select high and the rest low
`define ADSL_PIN_RESET       5'h04
// control source, one-hot
`define ADSL_SRC_EXTERNAL    3'h1
`define ADSL_SRC_DAC_INTREF  3'h2
`define ADSL_SRC_DAC_EXTREF  3'h4
`define ADSL_SRC_RESET       3'h1
// attenuation step in thousandths of a dB per code step
`define ADSL_STEP_MDB        16'h0078
`define ADSL_ATTEN_WIDTH     16

`endif

/* adsl_sync.v */
/*
 * two flip-flop synchroniser for a group of pin inputs.
 * assumes pins are asynchronous to clock; first stage feeds only the second.
 */
`timescale 1ns/1ps
module adsl_sync #(
	parameter WIDTH = 1
) (
	input  wire             clock,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] async_in,
	input  wire [WIDTH-1:0] reset_val,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] hold_reg;

	// stages hold pin xor idle level, so a constant reset yields the idle level
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= {WIDTH{1'b0}};
			hold_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in ^ reset_val;
			hold_reg <= meta_reg;
		end
	end

	// undo the xor after the second stage; a constant term adds no glitch
	assign sync_out = hold_reg ^ reset_val;
endmodule // adsl_sync

/* adsl_loader.v */
/*
 * serial loader for the attenuator control converter: three-wire write
 * only link, eight bit code, control source decode and step model.
 * assumes serial clock is far slower than clock (>= 4 clocks per half
 * period) and that select, data and enables are asynchronous pins.
 */
`timescale 1ns/1ps
`include "adsl_map.vh"
module adsl_loader #(
	parameter CODE_WIDTH = `ADSL_CODE_WIDTH
) (
	input  wire                          clock,
	input  wire                          rst_n,
	input  wire                          ser_clk,
	input  wire                          ser_data,
	input  wire                          sel_n,
	input  wire                          converter_enable_pin,
	input  wire                          ref_select_pin,
	output reg  [CODE_WIDTH-1:0]         dac_code,
	output reg                           code_update,
	output reg                           frame_error,
	output reg                           dac_enable,
	output reg                           use_internal_ref,
	output reg                           use_external_control_voltage,
	output reg  [2:0]                    control_source,
	output reg  [`ADSL_ATTEN_WIDTH-1:0]  atten_mdb
);
	wire [4:0] pins_sync;
	wire       sclk_s;
	wire       sdat_s;
	wire       sel_n_s;
	wire       en_s;
	wire       ref_s;

	// select idles high, so its synchroniser resets high
	adsl_sync #(
		.WIDTH(5)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({ser_clk, ser_data, sel_n, converter_enable_pin, ref_select_pin}),
		.reset_val(`ADSL_PIN_RESET),
		.sync_out (pins_sync)
	);
	assign sclk_s  = pins_sync[4];
	assign sdat_s  = pins_sync[3];
	assign sel_n_s = pins_sync[2];
	assign en_s    = pins_sync[1];
	assign ref_s   = pins_sync[0];

	reg                          sclk_d_reg;
	reg                          sel_n_d_reg;
	reg  [CODE_WIDTH-1:0]        shift_reg;
	reg  [CODE_WIDTH-1:0]        shift_next;
	reg  [`ADSL_COUNT_WIDTH-1:0] count_reg;
	reg  [`ADSL_COUNT_WIDTH-1:0] count_next;
	reg  [2:0]                   source_next;
	reg                          enable_next;
	reg                          int_ref_next;
	reg                          ext_volt_next;
	wire                         sclk_rise;
	wire                         sel_rise;
	wire                         sel_fall;

	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sel_rise  = sel_n_s & ~sel_n_d_reg;
	assign sel_fall  = ~sel_n_s & sel_n_d_reg;

	// serial clock history, taken from second sync stage only
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
		end
	end

	// select history resets to its idle level, so reset release is no edge
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_n_d_reg <= 1'b1;
		end else begin
			sel_n_d_reg <= sel_n_s;
		end
	end

	// shifter: msb enters first and walks up to bit 7
	always @* begin
		shift_next = shift_reg;
		if (!sel_n_s && sclk_rise) begin
			shift_next = {shift_reg[CODE_WIDTH-2:0], sdat_s};
		end
		// edges while deselected fall through untouched
	end

	// bit count restarts on select fall and saturates, so long frames stay flagged
	always @* begin
		count_next = count_reg;
		if (sel_fall) begin
			count_next = {`ADSL_COUNT_WIDTH{1'b0}};
		end
		if (!sel_n_s && sclk_rise && (count_next != `ADSL_COUNT_MAX)) begin
			count_next = count_next + 4'h1;
		end
	end

	// shift register
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= `ADSL_CODE_RESET;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// bit counter
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= {`ADSL_COUNT_WIDTH{1'b0}};
		end else begin
			count_reg <= count_next;
		end
	end

	// applied code moves only on select rising; longer frames keep last eight
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dac_code <= `ADSL_CODE_RESET;
		end else begin
			if (sel_rise) begin
				dac_code <= shift_reg;
			end
		end
	end

	// one-cycle load strobe
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			code_update <= 1'b0;
		end else begin
			code_update <= sel_rise;
		end
	end

	// a wrong-length frame still loads; the flag only reports the count
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_error <= 1'b0;
		end else begin
			if (sel_rise) begin
				frame_error <= (count_reg != `ADSL_FRAME_BITS);
			end
		end
	end

	// control source decode, reference select ignored when disabled
	always @* begin
		source_next   = `ADSL_SRC_EXTERNAL;
		enable_next   = 1'b0;
		int_ref_next  = 1'b0;
		ext_volt_next = 1'b1;
		case ({en_s, ref_s})
			2'b11: begin
				source_next   = `ADSL_SRC_DAC_INTREF;
				enable_next   = 1'b1;
				int_ref_next  = 1'b1;
				ext_volt_next = 1'b0;
			end
			2'b10: begin
				source_next   = `ADSL_SRC_DAC_EXTREF;
				enable_next   = 1'b1;
				int_ref_next  = 1'b0;
				ext_volt_next = 1'b0;
			end
			default: begin
				source_next   = `ADSL_SRC_EXTERNAL;
				enable_next   = 1'b0;
				int_ref_next  = 1'b0;
				ext_volt_next = 1'b1;
			end
		endcase
	end

	// one-hot source, for whoever steers the attenuator
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			control_source <= `ADSL_SRC_RESET;
		end else begin
			control_source <= source_next;
		end
	end

	// converter runs only while enabled
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dac_enable <= 1'b0;
		end else begin
			dac_enable <= enable_next;
		end
	end

	// on-chip reference only with converter enabled
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			use_internal_ref <= 1'b0;
		end else begin
			use_internal_ref <= int_ref_next;
		end
	end

	// external voltage steers while converter is off
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			use_external_control_voltage <= 1'b1;
		end else begin
			use_external_control_voltage <= ext_volt_next;
		end
	end

	// attenuation model; a product is cheap next to a table at this width
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			atten_mdb <= {`ADSL_ATTEN_WIDTH{1'b0}};
		end else begin
			atten_mdb <= dac_code * `ADSL_STEP_MDB;
		end
	end
endmodule // adsl_loader

/* adsl_checker.sv */
/* checker for the attenuator loader: load timing, step model, mode decode.
   assumes it is bound to adsl_loader and sees only its ports. */
`timescale 1ns/1ps
module adsl_checker #(parameter CODE_WIDTH = 8) (
	input wire clock, rst_n, ser_clk, ser_data, sel_n, converter_enable_pin, ref_select_pin,
	input wire [CODE_WIDTH-1:0] dac_code,
	input wire code_update, frame_error, dac_enable, use_internal_ref,
	input wire use_external_control_voltage,
	input wire [2:0] control_source,
	input wire [15:0] atten_mdb);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// load is seen three edges after select is seen high, and only then
	a_load_delay: assert property ($rose(sel_n) |-> ##3 code_update)
		else $error("load late");
	a_load_cause: assert property (code_update |-> $past(sel_n, 3) && !$past(sel_n, 4))
		else $error("load without select rise");
	a_pulse_once: assert property (code_update |=> !code_update)
		else $error("load pulse too long");
	a_code_held: assert property (!code_update |-> $stable(dac_code) && $stable(frame_error))
		else $error("code moved between loads");
	a_idle_quiet: assert property (sel_n [*6] |=> !code_update)
		else $error("load while deselected");
	a_step_size: assert property (code_update |=> atten_mdb == {8'h00, dac_code} * 16'h0078)
		else $error("attenuation step wrong");
	// pins need three edges to reach the decode
	a_ext_mode: assert property (!converter_enable_pin [*4] |-> control_source == 3'h1
		&& use_external_control_voltage && !dac_enable) else $error("external mode wrong");
	a_int_ref: assert property ((converter_enable_pin && ref_select_pin) [*4] |->
		control_source == 3'h2 && use_internal_ref && dac_enable) else $error("internal ref wrong");
	a_ext_ref: assert property ((converter_enable_pin && !ref_select_pin) [*4] |->
		control_source == 3'h4 && !use_internal_ref) else $error("external ref wrong");
	cover property (code_update && frame_error);
	cover property (code_update && !frame_error);
	cover property (control_source == 3'h4);
endmodule // adsl_checker

/* adsl_host.sv */
/* host model driving the three-wire link at a 160 ns serial clock.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module adsl_host (
	output logic ser_clk = 1'b0,
	output logic ser_data = 1'b1,
	output logic sel_n = 1'b1);
	// one frame, msb first; released data shows the inverse, no pull on the line
	task automatic send(input logic [15:0] v, input int n);
		#7 sel_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			ser_data = v[i];
			#80 ser_clk = 1'b1;
			#80 ser_clk = 1'b0;
		end
		#80 sel_n = 1'b1;
		ser_data = ~ser_data;
	endtask
	// clock pulses with select high, a host slip the device must ignore
	task automatic idle_clk(input int n);
		repeat (n) begin
			#80 ser_clk = 1'b1;
			#80 ser_clk = 1'b0;
		end
	endtask
endmodule // adsl_host

/* testbench.sv */
/* testbench for the attenuator loader: frames, short frames, idle clocks, modes.
   assumes adsl_host drives the link; the checker is bound at the foot. */
`timescale 1ns/1ps
module testbench;
	logic clock = 0, rst_n = 0, converter_enable_pin = 0, ref_select_pin = 0;
	wire ser_clk, ser_data, sel_n, code_update, frame_error, dac_enable, use_internal_ref;
	wire use_external_control_voltage;
	wire [7:0] dac_code;
	wire [2:0] control_source;
	wire [15:0] atten_mdb;
	int mismatches = 0, tests_run = 0;
	always #10 clock = ~clock;
	adsl_host adsl_host_inst (.*);
	adsl_loader adsl_loader_inst (.*);
	task automatic chk(input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// wait for the load pulse, bounded, then judge code, flag and step
	task automatic land(input logic [7:0] c, input logic e);
		for (int i = 0; i < 20 && code_update !== 1'b1; i++) @(posedge clock) #1;
		chk(code_update, 1'b1);
		chk(dac_code, c);
		chk(frame_error, e);
		@(posedge clock) #1 chk(atten_mdb, c * 16'h0078);
	endtask
	task automatic t_frames;
		logic [7:0] v [4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
		foreach (v[i]) begin
			adsl_host_inst.send(v[i], 8);
			land(v[i], 1'b0);
		end
		$display("frames done");
	endtask
	// short frames load the shifter tail; idle clocks must not shift
	task automatic t_short;
		adsl_host_inst.send(16'h0016, 5);
		land(8'hF6, 1'b1);
		adsl_host_inst.idle_clk(6);
		repeat (8) @(posedge clock);
		#1 chk(dac_code, 16'h00F6);
		adsl_host_inst.send(16'h0016, 5);
		land(8'hD6, 1'b1);
		adsl_host_inst.send(16'h005A, 8);
		land(8'h5A, 1'b0);
		adsl_host_inst.send(16'h01C3, 9);
		land(8'hC3, 1'b1);
		$display("short done");
	endtask
	task automatic t_modes;
		logic [2:0] src [4] = '{3'h1, 3'h1, 3'h4, 3'h2};
		for (int m = 0; m < 4; m++) begin
			@(posedge clock);
			converter_enable_pin <= m[1];
			ref_select_pin <= m[0];
			repeat (4) @(posedge clock);
			#1 chk(control_source, src[m]);
			chk(use_external_control_voltage, !m[1]);
			chk(dac_enable, m[1]);
			chk(use_internal_ref, m[1] & m[0]);
		end
		$display("modes done");
	endtask
	task results;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_modes;
		t_frames;
		t_short;
		results;
	end
	// whole run needs about 13 us
	initial begin
		#200000;
		mismatches++;
		results;
	end
endmodule // testbench
bind adsl_loader adsl_checker #(.CODE_WIDTH(CODE_WIDTH)) adsl_checker_inst (.*);
